// ---- pd_hold_pkg.sv ----
// Package for the pin power-down hold block: widths, reset values and timing counts.
// Assumes a single 200 MHz system clock.
package pd_hold_pkg;

	localparam int NUM_IO = 8;
	localparam int NUM_IN = 4;

	localparam int CLK_PERIOD_PS = 5000;
	localparam int RECOVER_TIME_US = 1;
	localparam int RECOVER_CYCLES = (RECOVER_TIME_US * 1000000) / CLK_PERIOD_PS;

	localparam logic [NUM_IO-1:0] OUT_RST = 8'h00;
	localparam logic [NUM_IO-1:0] OE_RST = 8'h00;
	localparam logic [NUM_IN-1:0] IN_RST = 4'h0;

	typedef struct packed {
		logic [NUM_IO-1:0] data;
		logic [NUM_IO-1:0] oe;
	} pin_drive_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DOWN,
		ST_RECOVER
	} pd_state_t;

endpackage

// ---- pd_hold.sv ----
// Power-down hold block: freezes pin drive and internal state while the power-down pin is high.
// Assumes the pin and user inputs come from outside the clock domain; the core logic is on clk_sys_i.
`timescale 1ns/1ps
// Behaviour
// - With the option enabled, a high power-down pin enters power-down.
// - Outputs and internal state are latched and held during power-down.
// - Outputs in high impedance at entry stay high impedance throughout.
// - All inputs except the power-down pin are blocked during power-down.
// - Pin hold latches stay active so no pin floats.
// - Without the option, the pin is an ordinary input.
// - With the option, the pin does not feed the logic array.
// - After the pin falls, one microsecond of recovery before resuming.
// - Pin-sourced and term-sourced enables and clocks are all frozen alike.
module pd_hold
	import pd_hold_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	// Configuration.
	input  wire logic              pd_enable_i,
	// Pins.
	input  wire logic              power_down_pin_i,
	input  wire logic [NUM_IN-1:0] in_pin_i,
	input  wire logic [NUM_IO-1:0] io_pin_i,
	// Array side.
	input  wire pin_drive_t        array_drive_i,
	input  wire logic              array_clk_en_i,
	output logic [NUM_IN-1:0]      array_in_o,
	output logic [NUM_IO-1:0]      array_io_o,
	output logic                   array_pd_pin_o,
	output logic                   array_hold_o,
	// Pin drive.
	output logic [NUM_IO-1:0]      io_out_o,
	output logic [NUM_IO-1:0]      io_oe_o,
	output logic                   powered_down_o
);

	localparam int            CW       = $clog2(RECOVER_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(RECOVER_CYCLES - 1);
	localparam logic [CW-1:0] CNT_STEP = CW'(1);

	// Two-flop synchronisers on every pin.
	logic              pd_s1_q;
	logic              pd_s2_q;
	logic [NUM_IN-1:0] in_s1_q;
	logic [NUM_IN-1:0] in_s2_q;
	logic [NUM_IO-1:0] io_s1_q;
	logic [NUM_IO-1:0] io_s2_q;

	// Sequencer state and recovery counter.
	pd_state_t         state_q;
	pd_state_t         state_d;
	logic [CW-1:0]     cnt_q;
	logic [CW-1:0]     cnt_d;

	// Held drive and input levels.
	pin_drive_t        drive_q;
	logic [NUM_IN-1:0] in_hold_q;
	logic [NUM_IO-1:0] io_hold_q;
	logic              pd_raw_q;
	logic              pd_raw_d;

	// Decode.
	logic              pd_active;
	logic              frozen;
	logic              upd_drive;
	logic              upd_in;
	logic              cnt_zero;
	logic [CW-1:0]     cnt_dec;

	// Next-state decode.
	logic              go_down;
	logic              go_recover;
	logic              go_run;

	assign pd_active = pd_enable_i & pd_s2_q;
	assign frozen    = (state_q != ST_RUN);
	assign upd_drive = ~frozen & ~pd_active & array_clk_en_i;
	assign upd_in    = ~frozen & ~pd_active;
	assign cnt_zero  = (cnt_q == '0);
	assign cnt_dec   = cnt_q - CNT_STEP;
	assign pd_raw_d  = pd_enable_i ? 1'b0 : pd_s2_q;

	assign go_down    = pd_active;
	assign go_recover = ~pd_active;
	assign go_run     = ~pd_active & cnt_zero;

	// Only the second flop of each synchroniser is read, so a metastable first stage never reaches logic.
	always_ff @(posedge clk_sys_i) begin
		pd_s1_q <= power_down_pin_i;
		pd_s2_q <= pd_s1_q;
	end

	always_ff @(posedge clk_sys_i) begin
		in_s1_q <= in_pin_i;
		in_s2_q <= in_s1_q;
	end

	always_ff @(posedge clk_sys_i) begin
		io_s1_q <= io_pin_i;
		io_s2_q <= io_s1_q;
	end

	// A pin rise during recovery returns straight to the frozen state.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_RUN: begin
				if (go_down) begin
					state_d = ST_DOWN;
				end
			end
			ST_DOWN: begin
				if (go_recover) begin
					state_d = ST_RECOVER;
					cnt_d = CNT_LOAD;
				end
			end
			ST_RECOVER: begin
				if (go_down) begin
					state_d = ST_DOWN;
				end else if (go_run) begin
					state_d = ST_RUN;
				end else begin
					cnt_d = cnt_dec;
				end
			end
			default: begin
				state_d = ST_RUN;
				cnt_d = '0;
			end
		endcase
	end

	// The recovery wait is also a guard: the far side's inputs may be stale, so nothing is sampled until it ends.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Data and enable of one pin are held together, so a pin off at entry stays off.
	for (genvar i = 0; i < NUM_IO; i++) begin : g_drive
		always_ff @(posedge clk_sys_i) begin
			if (!nrst_i) begin
				drive_q.data[i] <= OUT_RST[i];
				drive_q.oe[i] <= OE_RST[i];
			end else if (upd_drive) begin
				drive_q.data[i] <= array_drive_i.data[i];
				drive_q.oe[i] <= array_drive_i.oe[i];
			end
		end
	end

	// Input hold latches keep the last level seen, so blocked inputs never float.
	for (genvar i = 0; i < NUM_IN; i++) begin : g_in_hold
		always_ff @(posedge clk_sys_i) begin
			if (!nrst_i) begin
				in_hold_q[i] <= IN_RST[i];
			end else if (upd_in) begin
				in_hold_q[i] <= in_s2_q[i];
			end
		end
	end

	// The same keeper per two-way pin; the level read back includes our own drive.
	for (genvar i = 0; i < NUM_IO; i++) begin : g_io_hold
		always_ff @(posedge clk_sys_i) begin
			if (!nrst_i) begin
				io_hold_q[i] <= OUT_RST[i];
			end else if (upd_in) begin
				io_hold_q[i] <= io_s2_q[i];
			end
		end
	end

	// With the option on, the pin never reaches the array as an ordinary input.
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			pd_raw_q <= 1'b0;
		end else begin
			pd_raw_q <= pd_raw_d;
		end
	end

	// Array side.
	assign array_in_o = in_hold_q;
	assign array_io_o = io_hold_q;
	assign array_pd_pin_o = pd_raw_q;
	assign array_hold_o = frozen | pd_active;

	// Pin side.
	assign io_out_o = drive_q.data;
	assign io_oe_o = drive_q.oe;
	assign powered_down_o = frozen;

endmodule

// ---- pd_hold_props.sv ----
// Checker for the pd_hold port behaviour.
// Assumes the pins only move at clock edges.
`timescale 1ns/1ps
module pd_hold_props
	import pd_hold_pkg::*;
(
	// Clock and reset.
	input wire logic              clk_sys_i,
	input wire logic              nrst_i,
	// Watched ports.
	input wire logic              pd_enable_i,
	input wire logic              power_down_pin_i,
	input wire logic [NUM_IN-1:0] array_in_o,
	input wire logic [NUM_IO-1:0] array_io_o,
	input wire logic              array_pd_pin_o,
	input wire logic              array_hold_o,
	input wire logic [NUM_IO-1:0] io_out_o,
	input wire logic [NUM_IO-1:0] io_oe_o,
	input wire logic              powered_down_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence s_down;
		powered_down_o ##1 powered_down_o;
	endsequence
	a_out_held: assert property (s_down |-> $stable(io_out_o)) else $error("out moved");
	a_oe_held: assert property (s_down |-> $stable(io_oe_o)) else $error("oe moved");
	a_in_blocked: assert property (s_down |-> $stable(array_in_o)) else $error("in moved");
	a_io_kept: assert property (s_down |-> $stable(array_io_o)) else $error("io moved");
	a_entry_delay: assert property ($rose(power_down_pin_i) && pd_enable_i |-> ##3 powered_down_o)
		else $error("late entry");
	a_no_option: assert property (!pd_enable_i |-> !powered_down_o) else $error("down unasked");
	a_pin_cut: assert property (pd_enable_i ##1 pd_enable_i |-> !array_pd_pin_o) else $error("pin leak");
	a_recover_len: assert property ($fell(power_down_pin_i) && powered_down_o
		|-> ##200 powered_down_o ##[1:6] !powered_down_o) else $error("bad recovery");
	a_hold_flag: assert property (powered_down_o |-> array_hold_o) else $error("no hold");
endmodule
bind pd_hold pd_hold_props pd_hold_props_i (.*);

// ---- pd_sys_model.sv ----
// System logic that drives the power-down pin.
// Assumes the bench settles other inputs before asking.
`timescale 1ns/1ps
module pd_sys_model (
	// Clock.
	input  wire logic clk_sys_i,
	// Request and pin.
	input  wire logic req_i,
	output logic      power_down_pin_o
);
	logic [1:0] dly_q = 2'h0;
	// Two cycles of lag give the inputs 10 ns to settle before the pin moves.
	always @(posedge clk_sys_i) begin
		dly_q <= {dly_q[0], req_i};
	end
	assign power_down_pin_o = dly_q[1];
endmodule

// ---- tb_top.sv ----
// Bench for pd_hold: run, freeze and bypass cases.
// Assumes a 200 MHz clock and the system pin model.
`timescale 1ns/1ps
module tb_top;
	import pd_hold_pkg::*;
	logic clk_sys_i = 0, nrst_i = 0, en = 1, req = 0, clken = 1, pin, hold, pd, ppin;
	logic [NUM_IN-1:0] in = 4'h0, ain;
	logic [NUM_IO-1:0] ext = 8'h00, aio, out, oe;
	pin_drive_t drv = '0;
	int err_count = 0, compares = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	wire [NUM_IO-1:0] io = (oe & out) | (~oe & ext);
	pd_sys_model pd_sys_model_i (.clk_sys_i(clk_sys_i), .req_i(req), .power_down_pin_o(pin));
	pd_hold pd_hold_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pd_enable_i(en), .power_down_pin_i(pin),
		.in_pin_i(in), .io_pin_i(io), .array_drive_i(drv), .array_clk_en_i(clken), .array_in_o(ain),
		.array_io_o(aio), .array_pd_pin_o(ppin), .array_hold_o(hold), .io_out_o(out), .io_oe_o(oe),
		.powered_down_o(pd));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("err_count=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task wpd(input logic v);
		for (int k = 0; k < 400 && pd !== v; k++) cyc(1);
		chk(pd, v);
	endtask
	task t_run;
		@(posedge clk_sys_i);
		drv <= 16'ha50f;
		in <= 4'h9;
		ext <= 8'h3c;
		cyc(6);
		chk({out, oe}, 16'ha50f);
		chk(ain, 16'h9);
		chk(aio, 16'h35);
		@(posedge clk_sys_i);
		clken <= 1'b0;
		drv <= 16'h1234;
		cyc(4);
		chk({out, oe}, 16'ha50f);
		@(posedge clk_sys_i);
		clken <= 1'b1;
		drv <= 16'ha50f;
		cyc(2);
	endtask
	task t_down;
		@(posedge clk_sys_i);
		req <= 1'b1;
		wpd(1'b1);
		@(posedge clk_sys_i);
		drv <= 16'h5af0;
		in <= 4'h6;
		ext <= 8'hc3;
		cyc(10);
		chk({out, oe}, 16'ha50f);
		chk(ain, 16'h9);
		chk(aio, 16'h35);
		chk(ppin, 16'h0);
		@(posedge clk_sys_i);
		req <= 1'b0;
		wpd(1'b0);
		cyc(4);
		chk({out, oe}, 16'h5af0);
		chk(ain, 16'h6);
	endtask
	task t_off;
		@(posedge clk_sys_i);
		en <= 1'b0;
		req <= 1'b1;
		in <= 4'ha;
		cyc(8);
		chk(pd, 16'h0);
		chk(ppin, 16'h1);
		chk(ain, 16'ha);
	endtask
	initial begin
		cyc(4);
		nrst_i <= 1'b1;
		t_run();
		t_down();
		t_off();
		summarize();
	end
	initial begin
		#20000;
		err_count++;
		summarize();
	end
endmodule
